// >>> core/led_blink_sequence_timing.sv
/*
  Blink-sequence timing for the first LED sink plus setup registers of both
  sinks: register file on a byte-wide internal register port, phase
  sequencer in 64 ms steps, duty-cycle gating of the light signal.
  Assumes the serial host interface in front presents single-cycle read
  and write strobes on clk_sys, and that rst_n follows power-on reset.
*/
// Notes on behaviour
// R1: phases one to four each last their 7-bit code times 64 ms.
// R2: repeat-period phase lasts its 7-bit code times 64 ms; zero means none.
// R3: light signal high for (code+1)/32 of every 8 ms period.
// R4: duty code zero gives 250 us high then 7.75 ms low.
// R5: duty code all ones keeps the light signal always high.
// R6: lit time is a 5-bit code times 64 ms.
// R7: unused upper bits read zero and ignore writes.
// R8: every register here clears to zero at power-on reset.
// R9: second sink register holds 4-bit current code and ramp bit 5.
// R10: first sink has the same current code and ramp bit register.
// R11: step ticks derive from a slow time base; phases cycle one to four, repeat.
`timescale 1ns/1ps
module led_blink_sequence_timing
  import led_blink_pkg::*;
#(
  parameter int SLOT_LEN = SLOT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rd_data,
  output logic chan_a_light_signal,
  output logic [LEVEL_W-1:0] chan_a_sink_level,
  output logic chan_a_soft_ramp,
  output logic [LEVEL_W-1:0] chan_b_sink_level,
  output logic chan_b_soft_ramp,
  output seq_phase_t seq_phase
);

  localparam int STEP_W = $clog2(PERIODS_PER_STEP);
  localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(PERIODS_PER_STEP - 1);
  localparam int IDX_ONE = 0;
  localparam int IDX_TWO = 1;
  localparam int IDX_THREE = 2;
  localparam int IDX_FOUR = 3;
  localparam int IDX_REPEAT = 4;
  localparam int IDX_NONE = 7;

  logic [LEN_W-1:0] len_reg [NUM_LEN];
  logic [DUTY_W-1:0] duty_reg;
  logic [ON_W-1:0] on_dur_reg;
  logic [LEVEL_W-1:0] a_level_reg;
  logic a_ramp_reg;
  logic [LEVEL_W-1:0] b_level_reg;
  logic b_ramp_reg;

  seq_phase_t phase_reg;
  seq_phase_t phase_next;
  logic [STEP_W-1:0] period_cnt_reg;
  logic [LEN_W-1:0] step_cnt_reg;
  logic [LEN_W-1:0] cur_len;
  logic pwm_level;
  logic period_tick;
  logic step_tick;
  logic advance;
  logic lit;

  // length register index for an address, IDX_NONE when not a length
  function automatic int len_index(input logic [7:0] addr);
    case (addr)
      OFS_A_PHASE1: len_index = IDX_ONE;
      OFS_A_PHASE2: len_index = IDX_TWO;
      OFS_A_PHASE3: len_index = IDX_THREE;
      OFS_A_PHASE4: len_index = IDX_FOUR;
      OFS_A_REPEAT: len_index = IDX_REPEAT;
      default: len_index = IDX_NONE;
    endcase
  endfunction

  // length register index for a sequence phase
  function automatic int phase_index(input seq_phase_t ph);
    case (ph)
      PH_ONE: phase_index = IDX_ONE;
      PH_TWO: phase_index = IDX_TWO;
      PH_THREE: phase_index = IDX_THREE;
      PH_FOUR: phase_index = IDX_FOUR;
      default: phase_index = IDX_REPEAT;
    endcase
  endfunction

  // register writes: only the implemented bits are stored
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LEN; gi++) begin : g_len
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          len_reg[gi] <= REG_RESET[LEN_W-1:0]; // R8
        end else if (reg_wr_en && len_index(reg_addr) == gi) begin
          len_reg[gi] <= reg_wr_data[LEN_W-1:0]; // R1 R2 R7
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      duty_reg <= REG_RESET[DUTY_W-1:0]; // R8
    end else if (reg_wr_en && reg_addr == OFS_A_DUTY) begin
      duty_reg <= reg_wr_data[DUTY_W-1:0]; // R7
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      on_dur_reg <= REG_RESET[ON_W-1:0]; // R8
    end else if (reg_wr_en && reg_addr == OFS_A_ON_DUR) begin
      on_dur_reg <= reg_wr_data[ON_W-1:0]; // R6 R7
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      a_level_reg <= REG_RESET[LEVEL_W-1:0]; // R8
      a_ramp_reg <= REG_RESET[RAMP_BIT];
    end else if (reg_wr_en && reg_addr == OFS_A_CURRENT_RAMP) begin
      a_level_reg <= reg_wr_data[LEVEL_W-1:0]; // R10
      a_ramp_reg <= reg_wr_data[RAMP_BIT]; // R10
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      b_level_reg <= REG_RESET[LEVEL_W-1:0]; // R8
      b_ramp_reg <= REG_RESET[RAMP_BIT];
    end else if (reg_wr_en && reg_addr == OFS_B_CURRENT_RAMP) begin
      b_level_reg <= reg_wr_data[LEVEL_W-1:0]; // R9
      b_ramp_reg <= reg_wr_data[RAMP_BIT]; // R9
    end
  end

  // registered read data, held until the next read strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rd_data <= RD_UNMAPPED;
    end else if (reg_rd_en) begin
      case (reg_addr)
        OFS_A_PHASE1,
        OFS_A_PHASE2,
        OFS_A_PHASE3,
        OFS_A_PHASE4,
        OFS_A_REPEAT: begin
          reg_rd_data <= {1'b0, len_reg[len_index(reg_addr)]}; // R7
        end
        OFS_A_DUTY: begin
          reg_rd_data <= {3'h0, duty_reg}; // R7
        end
        OFS_A_ON_DUR: begin
          reg_rd_data <= {3'h0, on_dur_reg}; // R7
        end
        OFS_A_CURRENT_RAMP: begin
          reg_rd_data <= {2'h0, a_ramp_reg, 1'b0, a_level_reg}; // R7 R10
        end
        OFS_B_CURRENT_RAMP: begin
          reg_rd_data <= {2'h0, b_ramp_reg, 1'b0, b_level_reg}; // R7 R9
        end
        default: begin
          reg_rd_data <= RD_UNMAPPED;
        end
      endcase
    end
  end

  // duty-cycle generator also supplies the 8 ms period tick
  dimming_pwm #(
    .SLOT_LEN(SLOT_LEN)
  ) u_pwm (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .duty_code(duty_reg),
    .pwm_level(pwm_level),
    .period_tick(period_tick)
  );

  // eight periods make one 64 ms sequence step
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      period_cnt_reg <= '0;
    end else if (period_tick) begin
      period_cnt_reg <= period_cnt_reg + STEP_W'(1); // R11
    end
  end

  assign step_tick = period_tick && (period_cnt_reg == STEP_LAST); // R11
  assign cur_len = len_reg[phase_index(phase_reg)];
  // zero-length phase passes in one clock
  assign advance = (step_cnt_reg >= cur_len); // R1 R2

  always_comb begin
    case (phase_reg)
      PH_ONE: phase_next = PH_TWO;
      PH_TWO: phase_next = PH_THREE;
      PH_THREE: phase_next = PH_FOUR;
      PH_FOUR: phase_next = PH_REPEAT;
      PH_REPEAT: phase_next = PH_ONE;
      default: phase_next = PH_ONE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= PH_ONE;
    end else if (advance) begin
      phase_reg <= phase_next; // R11
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      step_cnt_reg <= '0;
    end else if (advance) begin
      step_cnt_reg <= '0;
    end else if (step_tick) begin
      step_cnt_reg <= step_cnt_reg + LEN_W'(1); // R1 R2
    end
  end

  // lit during the first on-time steps of phases one and three
  assign lit = (phase_reg == PH_ONE || phase_reg == PH_THREE) &&
               (step_cnt_reg < LEN_W'(on_dur_reg)); // R6

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chan_a_light_signal <= 1'b0;
    end else begin
      chan_a_light_signal <= lit && pwm_level; // R3
    end
  end

  assign chan_a_sink_level = a_level_reg;
  assign chan_a_soft_ramp = a_ramp_reg;
  assign chan_b_sink_level = b_level_reg;
  assign chan_b_soft_ramp = b_ramp_reg;
  assign seq_phase = phase_reg;

endmodule

// >>> core/led_blink_pkg.sv
/*
  Holds the register map, field layout, reset values, sequence states and
  timing constants of the blink-sequence block.
  Assumes a 125 MHz system clock and byte-wide register access.
*/
package led_blink_pkg;

  localparam logic [7:0] OFS_A_CURRENT_RAMP = 8'h47;
  localparam logic [7:0] OFS_A_PHASE1 = 8'h48;
  localparam logic [7:0] OFS_A_PHASE2 = 8'h49;
  localparam logic [7:0] OFS_A_PHASE3 = 8'h4a;
  localparam logic [7:0] OFS_A_PHASE4 = 8'h4b;
  localparam logic [7:0] OFS_A_REPEAT = 8'h4c;
  localparam logic [7:0] OFS_A_DUTY = 8'h4d;
  localparam logic [7:0] OFS_A_ON_DUR = 8'h4e;
  localparam logic [7:0] OFS_B_CURRENT_RAMP = 8'h4f;

  localparam int LEN_W = 7;
  localparam int DUTY_W = 5;
  localparam int ON_W = 5;
  localparam int LEVEL_W = 4;
  localparam int RAMP_BIT = 5;
  localparam int NUM_LEN = 5;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // timing: one duty slot is 1/32 of the 8 ms period
  localparam int CLK_PERIOD_PS = 8000;
  localparam int PERIOD_TIME_US = 8000;
  localparam int SLOTS_PER_PERIOD = 32;
  localparam int SLOT_TIME_PS = (PERIOD_TIME_US / SLOTS_PER_PERIOD) * 1000000;
  localparam int SLOT_CYCLES = (SLOT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STEP_TIME_US = 64000;
  localparam int PERIODS_PER_STEP = STEP_TIME_US / PERIOD_TIME_US;

  typedef enum logic [2:0] {
    PH_ONE = 3'h0,
    PH_TWO = 3'h1,
    PH_THREE = 3'h3,
    PH_FOUR = 3'h2,
    PH_REPEAT = 3'h6
  } seq_phase_t;

endpackage

// >>> core/dimming_pwm.sv
/*
  Duty-cycle generator: 32 slots per period, high for (code+1) slots.
  Assumes a synchronous duty code from the register file on the same clock.
*/
`timescale 1ns/1ps
module dimming_pwm
  import led_blink_pkg::*;
#(
  parameter int SLOT_LEN = SLOT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [DUTY_W-1:0] duty_code,
  output logic pwm_level,
  output logic period_tick
);

  localparam int PRE_W = $clog2(SLOT_LEN + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(SLOT_LEN - 1);
  localparam logic [DUTY_W-1:0] SLOT_LAST = DUTY_W'(SLOTS_PER_PERIOD - 1);

  logic [PRE_W-1:0] pre_reg;
  logic [DUTY_W-1:0] slot_reg;
  logic slot_tick;

  assign slot_tick = (pre_reg == PRE_LAST);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg <= '0;
    end else if (slot_tick) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + PRE_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      slot_reg <= '0;
    end else if (slot_tick) begin
      slot_reg <= slot_reg + DUTY_W'(1);
    end
  end

  // slot 0 always high, so code 0 gives one slot and all ones never goes low
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pwm_level <= 1'b0;
    end else begin
      pwm_level <= (slot_reg <= duty_code); // R3 R4 R5
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      period_tick <= 1'b0;
    end else begin
      period_tick <= slot_tick && (slot_reg == SLOT_LAST);
    end
  end

endmodule

// >>> tb/led_blink_sequence_timing_chk.sv
/*
  Port-level checker for the blink-sequence block.
  Assumes it is bound to the block's top module and sees only its ports.
*/
`timescale 1ns/1ps
module led_blink_sequence_timing_chk
  import led_blink_pkg::*;
#(
  parameter int SLOT_LEN = SLOT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  input wire logic chan_a_light_signal,
  input wire logic [LEVEL_W-1:0] chan_a_sink_level,
  input wire logic chan_a_soft_ramp,
  input wire logic [LEVEL_W-1:0] chan_b_sink_level,
  input wire logic chan_b_soft_ramp,
  input wire seq_phase_t seq_phase
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  function automatic seq_phase_t succ(seq_phase_t p);
    case (p)
      PH_ONE: succ = PH_TWO;
      PH_TWO: succ = PH_THREE;
      PH_THREE: succ = PH_FOUR;
      PH_FOUR: succ = PH_REPEAT;
      default: succ = PH_ONE;
    endcase
  endfunction

  AST_RD_LEN_TOP: assert property (reg_rd_en && reg_addr inside {[8'h48:8'h4c]}
    |=> reg_rd_data[7] == 1'b0) else $error("length register bit 7 read nonzero");
  AST_RD_DUTY_TOP: assert property (reg_rd_en && reg_addr inside {8'h4d, 8'h4e}
    |=> reg_rd_data[7:5] == 3'h0) else $error("duty or on-time upper bits nonzero");
  AST_RD_CTRL_SPARE: assert property (reg_rd_en && reg_addr inside {8'h47, 8'h4f}
    |=> reg_rd_data[7:6] == 2'h0 && !reg_rd_data[4]) else $error("ctrl spare bits nonzero");
  AST_RD_UNMAPPED: assert property (reg_rd_en && !(reg_addr inside {[8'h47:8'h4f]})
    |=> reg_rd_data == RD_UNMAPPED) else $error("unmapped read nonzero");
  AST_B_SETUP: assert property (reg_wr_en && reg_addr == 8'h4f |=>
    chan_b_sink_level == $past(reg_wr_data[3:0]) && chan_b_soft_ramp == $past(reg_wr_data[5]))
    else $error("second sink setup not taken");
  AST_A_SETUP: assert property (reg_wr_en && reg_addr == 8'h47 |=>
    chan_a_sink_level == $past(reg_wr_data[3:0]) && chan_a_soft_ramp == $past(reg_wr_data[5]))
    else $error("first sink setup not taken");
  AST_RESET_CLEAR: assert property (@(posedge clk_sys) disable iff (1'b0) !rst_n |->
    !chan_a_light_signal && chan_b_sink_level == 4'h0 && !chan_b_soft_ramp
    && chan_a_sink_level == 4'h0 && !chan_a_soft_ramp
    && reg_rd_data == 8'h00 && seq_phase == PH_ONE) else $error("outputs not cleared in reset");
  AST_PHASE_ORDER: assert property (seq_phase != $past(seq_phase) |->
    seq_phase == succ($past(seq_phase))) else $error("phase step out of order");
  AST_DARK_PHASE: assert property (seq_phase inside {PH_TWO, PH_FOUR, PH_REPEAT} [*3]
    |-> !chan_a_light_signal) else $error("light on in a dark phase");
endmodule

bind led_blink_sequence_timing led_blink_sequence_timing_chk #(.SLOT_LEN(SLOT_LEN)) chk_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
  .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
  .chan_a_light_signal(chan_a_light_signal), .chan_a_sink_level(chan_a_sink_level),
  .chan_a_soft_ramp(chan_a_soft_ramp), .chan_b_sink_level(chan_b_sink_level),
  .chan_b_soft_ramp(chan_b_soft_ramp), .seq_phase(seq_phase));

// >>> tb/led_blink_sequence_timing_test.sv
/*
  Self-checking bench: register rows, duty counts, one full phase loop.
  Assumes a short slot of 4 clocks, so a period is 128 and a step 1024.
*/
`timescale 1ns/1ps
module led_blink_sequence_timing_test
  import led_blink_pkg::*;
;
  localparam int SL = 4;
  localparam int STEP = SL * SLOTS_PER_PERIOD * PERIODS_PER_STEP;
  localparam logic [7:0] ROW_A [11] = '{8'h48, 8'h49, 8'h4a, 8'h4b, 8'h4c, 8'h4d,
    8'h4e, 8'h47, 8'h4f, 8'h50, 8'h46};
  localparam logic [7:0] ROW_W [11] = '{8'hff, 8'h80, 8'h55, 8'h2a, 8'hff, 8'hff,
    8'he5, 8'hff, 8'hf9, 8'hff, 8'hff};
  localparam logic [7:0] ROW_R [11] = '{8'h7f, 8'h00, 8'h55, 8'h2a, 8'h7f, 8'h1f,
    8'h05, 8'h2f, 8'h29, 8'h00, 8'h00};
  localparam logic [4:0] DUTY [4] = '{5'h00, 5'h07, 5'h1e, 5'h1f};
  localparam int LEN [5] = '{3, 1, 2, 0, 1};
  localparam int LITMAX [5] = '{STEP + 1, 0, STEP + 1, 0, 0};
  localparam seq_phase_t PH [5] = '{PH_ONE, PH_TWO, PH_THREE, PH_FOUR, PH_REPEAT};
  logic clk_sys = 1'b0;
  logic rst_n = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr_en = 1'b0;
  logic [7:0] reg_wr_data = 8'h00;
  logic reg_rd_en = 1'b0;
  logic [7:0] reg_rd_data;
  logic chan_a_light_signal;
  logic [LEVEL_W-1:0] chan_a_sink_level;
  logic chan_a_soft_ramp;
  logic [LEVEL_W-1:0] chan_b_sink_level;
  logic chan_b_soft_ramp;
  seq_phase_t seq_phase;
  int err_total = 0;
  int checked = 0;
  int n;
  int lit;
  logic [7:0] d;

  always #4 clk_sys = ~clk_sys;

  led_blink_sequence_timing #(.SLOT_LEN(SL)) led_blink_sequence_timing_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .chan_a_light_signal(chan_a_light_signal), .chan_a_sink_level(chan_a_sink_level),
    .chan_a_soft_ramp(chan_a_soft_ramp), .chan_b_sink_level(chan_b_sink_level),
    .chan_b_soft_ramp(chan_b_soft_ramp), .seq_phase(seq_phase));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %0h want %0h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    #1 reg_addr = a;
    reg_wr_data = v;
    reg_wr_en = 1'b1;
    @(posedge clk_sys);
    #1 reg_wr_en = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    #1 reg_addr = a;
    reg_rd_en = 1'b1;
    @(posedge clk_sys);
    #1 reg_rd_en = 1'b0;
    v = reg_rd_data;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk_sys);
    err_total++;
    tally_and_finish();
  end

  initial begin
    // a real falling edge, so the asynchronous reset fires
    #1 rst_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 9; i++) begin
      rd(8'h47 + 8'(i), d);
      chk(d, REG_RESET, "reset value");
    end
    for (int i = 0; i < 11; i++) begin
      wr(ROW_A[i], ROW_W[i]);
      rd(ROW_A[i], d);
      chk(d, ROW_R[i], "register row");
    end
    chk({chan_a_soft_ramp, chan_a_sink_level}, 5'h1f, "first sink setup");
    chk({chan_b_soft_ramp, chan_b_sink_level}, 5'h19, "second sink setup");
    wr(8'h4e, 8'h1f);
    wr(8'h48, 8'h7f);
    for (int k = 0; k < 4; k++) begin
      wr(8'h4d, {3'h0, DUTY[k]});
      repeat (256) @(posedge clk_sys);
      lit = 0;
      for (int c = 0; c < 128; c++) begin
        @(posedge clk_sys);
        #1 lit += (chan_a_light_signal === 1'b1);
      end
      chk(lit, (DUTY[k] + 1) * SL, "high clocks per period");
    end
    @(posedge clk_sys);
    #1 rst_n = 1'b0;
    @(posedge clk_sys);
    #1 rst_n = 1'b1;
    rd(8'h48, d);
    chk(d, REG_RESET, "cleared by second reset");
    chk({chan_a_soft_ramp, chan_a_sink_level}, 5'h00, "first sink cleared");
    chk({chan_b_soft_ramp, chan_b_sink_level}, 5'h00, "second sink cleared");
    wr(8'h4d, 8'h1f);
    wr(8'h4e, 8'h01);
    for (int i = 0; i < 5; i++) wr(8'h48 + 8'(i), 8'(LEN[i]));
    n = 0;
    while (seq_phase !== PH_REPEAT && n < 20000) begin
      @(posedge clk_sys);
      #1 n++;
    end
    while (seq_phase === PH_REPEAT && n < 20000) begin
      @(posedge clk_sys);
      #1 n++;
    end
    for (int i = 0; i < 5; i++) begin
      n = 0;
      lit = 0;
      while (seq_phase === PH[i] && n < 20000) begin
        @(posedge clk_sys);
        #1 n++;
        lit += (chan_a_light_signal === 1'b1);
      end
      if (LEN[i] == 0)
        chk(n, 1, "empty phase length");
      else
        chk(n > (LEN[i] - 1) * STEP && n <= LEN[i] * STEP, 1, "phase length");
      chk(lit <= LITMAX[i] && (LITMAX[i] == 0 || lit > 0), 1, "lit clocks");
    end
    chk(seq_phase, PH_ONE, "loop back to first phase");
    tally_and_finish();
  end
endmodule
